/* hw/origin_search_sequencer.sv */
// Origin search sequencer for one axis, with APB register access.
// Assumes limit, proximity and phase-Z pins are asynchronous, and that
// step pulses and absolute data come from logic on the same clock.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module origin_search_sequencer
    import origin_search_pkg::*;
#(
    parameter int HALT_CYCLES = DECEL_CYCLES
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [4:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire axis_pins_s  i_pins,
    input  wire logic        i_step,
    input  wire logic        i_step_up,
    input  wire logic        i_abs_valid,
    input  wire logic [31:0] i_abs_pos,
    output logic             o_cw_run,
    output logic             o_ccw_run,
    output logic             o_high_speed,
    output logic             o_counter_pulse,
    output logic             o_servo_run,
    output logic             o_encoder_data_request
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0] pin_raw;
    logic [3:0] pin_q;
    assign pin_raw = i_pins;

    for (genvar g = 0; g < 4; g++) begin : g_sync
        logic [SYNC_STAGES-1:0] sy;
        always_ff @(posedge i_ref_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                sy       <= '0;
                pin_q[g] <= 1'b0;
            end else begin
                sy <= {sy[SYNC_STAGES-2:0], pin_raw[g]};
                if (sy[1] == sy[2]) begin
                    pin_q[g] <= sy[2];
                end
            end
        end
    end

    logic cw_lim, ccw_lim, prox, z_pulse, z_prev, any_lim;
    logic [7:0] cfg;
    assign cw_lim  = pin_q[3];
    assign ccw_lim = pin_q[2];
    assign prox    = pin_q[1] ^ cfg[CFG_NC];
    assign any_lim = cw_lim | ccw_lim;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            z_prev <= 1'b0;
        end else begin
            z_prev <= pin_q[0];
        end
    end
    assign z_pulse = pin_q[0] & ~z_prev;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    search_state_e st;
    logic        dir;
    logic        err;
    logic        done;
    logic [31:0] pos;
    logic [31:0] home;
    logic        wr_en, go, init_cmd;
    logic        rev;
    assign wr_en    = psel & penable & pready & pwrite;
    assign go       = wr_en & (paddr == CMD_ADDR) & pwdata[CMD_START];
    assign init_cmd = wr_en & (paddr == CMD_ADDR) & pwdata[CMD_INIT];
    assign rev      = (cfg[1:0] == MODE_REVERSE);

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= 1'b0;
            if (psel & penable & ~pready) begin
                unique case (paddr)
                    CFG_ADDR:    prdata <= {24'h0, cfg};
                    CMD_ADDR:    prdata <= 32'h0;
                    STATUS_ADDR: prdata <= {22'h0, st, dir, err, done};
                    POS_ADDR:    prdata <= pos;
                    HOME_ADDR:   prdata <= home;
                    default: begin
                        prdata  <= 32'h0;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cfg <= CFG_RESET;
        end else if (wr_en && paddr == CFG_ADDR) begin
            cfg <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Servo run and encoder data request
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_servo_run            <= 1'b0;
            o_encoder_data_request <= 1'b0;
        end else begin
            o_servo_run <= cfg[CFG_SERVO];
            if (cfg[CFG_SERVO] && !o_servo_run) begin
                o_encoder_data_request <= 1'b1;
            end else if (!cfg[CFG_SERVO]) begin
                o_encoder_data_request <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Present position and power-up origin
    // ----------------------------------------------------------------
    logic abs_load, home_fixed;
    assign abs_load = i_abs_valid & o_encoder_data_request
                    & cfg[CFG_ABSSET];

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pos        <= 32'h0;
            home       <= 32'h0;
            home_fixed <= 1'b0;
        end else begin
            if (st == ST_ZWAIT && z_pulse) begin
                pos <= 32'h0;
            end else if (init_cmd) begin
                pos <= 32'h0;
            end else if (abs_load) begin
                pos <= i_abs_pos;
            end else if (i_step) begin
                pos <= i_step_up ? pos + 32'h1 : pos - 32'h1;
            end
            if (abs_load && !home_fixed) begin
                home <= i_abs_pos;
            end
            if (abs_load || i_step) begin
                home_fixed <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Search sequencer
    // ----------------------------------------------------------------
    logic [31:0] hcnt;
    logic        lim_hit;
    assign lim_hit = dir ? cw_lim : ccw_lim;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st   <= ST_IDLE;
            dir  <= 1'b1;
            err  <= 1'b0;
            done <= 1'b0;
            hcnt <= 32'h0;
        end else if (go) begin
            err  <= 1'b0;
            done <= 1'b0;
            if (cfg[1:0] == MODE_POWER_ON) begin
                st <= ST_RETURN;
            end else if (!rev) begin
                st  <= ST_FAST;
                dir <= cfg[CFG_ZDIR];
            end else if (!prox && !any_lim) begin
                st  <= ST_FAST;
                dir <= ~cfg[CFG_INIT];
            end else begin
                st  <= ST_FAST;
                dir <= cfg[CFG_INIT];
            end
        end else begin
            unique case (st)
                ST_IDLE: ;
                ST_FAST, ST_SLOW: begin
                    if (lim_hit && !rev) begin
                        st  <= ST_ERR;
                        err <= 1'b1;
                    end else if (lim_hit) begin
                        st   <= ST_HALT;
                        hcnt <= cfg[CFG_DECEL] ? 32'(HALT_CYCLES) : 32'h1;
                    end else if (st == ST_FAST && prox) begin
                        st <= ST_SLOW;
                    end else if (st == ST_SLOW && !prox) begin
                        if (dir == cfg[CFG_ZDIR]) begin
                            st <= ST_ZWAIT;
                        end else begin
                            st   <= ST_HALT;
                            hcnt <= cfg[CFG_DECEL] ? 32'(HALT_CYCLES)
                                                   : 32'h1;
                        end
                    end
                end
                ST_ZWAIT: begin
                    if (z_pulse) begin
                        st   <= ST_IDLE;
                        done <= 1'b1;
                    end else if (lim_hit) begin
                        st  <= ST_ERR;
                        err <= 1'b1;
                    end
                end
                ST_HALT: begin
                    if (hcnt <= 32'h1) begin
                        st  <= ST_FAST;
                        dir <= ~dir;
                    end else begin
                        hcnt <= hcnt - 32'h1;
                    end
                end
                ST_RETURN: begin
                    if (pos == home) begin
                        st   <= ST_IDLE;
                        done <= 1'b1;
                    end else begin
                        dir <= ($signed(pos) < $signed(home));
                    end
                end
                ST_ERR: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Drive outputs
    // ----------------------------------------------------------------
    logic moving;
    assign moving = (st == ST_FAST) | (st == ST_SLOW) | (st == ST_ZWAIT)
                  | ((st == ST_RETURN) & (pos != home));

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_cw_run        <= 1'b0;
            o_ccw_run       <= 1'b0;
            o_high_speed    <= 1'b0;
            o_counter_pulse <= 1'b0;
        end else begin
            o_cw_run        <= moving & dir;
            o_ccw_run       <= moving & ~dir;
            o_high_speed    <= (st == ST_FAST) | (st == ST_RETURN);
            o_counter_pulse <= (st == ST_HALT) & ~cfg[CFG_DECEL];
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    start_opposite_a: assert property (
        go && rev && !prox && !any_lim |=> st == ST_FAST
            && dir == !$past(cfg[CFG_INIT]))
        else $error("Start direction not opposite the initial direction.");
    ccw_start_a: assert property (
        go && rev && cfg[CFG_ZDIR] && !cfg[CFG_INIT] && (prox || any_lim)
            |=> !dir)
        else $error("Search did not start moving CCW.");
    halt_reverse_a: assert property (
        (st == ST_FAST || st == ST_SLOW) && rev && lim_hit && !go
            |=> st == ST_HALT ##1 !o_cw_run && !o_ccw_run)
        else $error("Limit did not halt the axis before reversing.");
    reverse_dir_a: assert property (
        st == ST_HALT && hcnt <= 32'h1 && !go |=> dir != $past(dir))
        else $error("Direction not reversed after halt.");
    no_z_error_a: assert property (
        st == ST_ZWAIT && lim_hit && !z_pulse && !go |=> st == ST_ERR && err)
        else $error("Missing phase-Z did not end in error.");
    one_dir_err_a: assert property (
        st == ST_FAST && !rev && lim_hit && !go |=> err)
        else $error("One-direction limit did not flag an error.");
    origin_z_a: assert property (
        st == ST_ZWAIT && z_pulse && !go |=> done && pos == 32'h0)
        else $error("Origin not set at phase-Z.");
    slow_speed_a: assert property (
        st == ST_SLOW && $past(st) == ST_SLOW |-> !o_high_speed)
        else $error("High speed kept while proximity active.");
    request_rise_a: assert property (
        $rose(o_servo_run) |-> $rose(o_encoder_data_request))
        else $error("Data request did not rise with servo run.");
    init_clear_a: assert property (
        init_cmd && !(st == ST_ZWAIT && z_pulse) |=> pos == 32'h0)
        else $error("Initialise did not clear position.");
    err_hold_a: assert property (
        st == ST_ERR && !go |=> st == ST_ERR ##1 !o_cw_run && !o_ccw_run)
        else $error("Axis not held stopped after error.");

    origin_found_c: cover property (st == ST_ZWAIT && z_pulse);
    reversal_c:     cover property (st == ST_HALT ##1 st == ST_FAST);
    error_c:        cover property ($rose(err));
    abs_load_c:     cover property (abs_load);

endmodule

/* hw/origin_search_pkg.sv */
// Constants, types and register map of the origin search sequencer.
// Assumes a single 125 MHz clock and an APB register bus.
package origin_search_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [4:0]  CFG_ADDR    = 5'h00;
    localparam logic [4:0]  CMD_ADDR    = 5'h04;
    localparam logic [4:0]  STATUS_ADDR = 5'h08;
    localparam logic [4:0]  POS_ADDR    = 5'h0c;
    localparam logic [4:0]  HOME_ADDR   = 5'h10;
    localparam logic [7:0]  CFG_RESET   = 8'h01;
    localparam int          CFG_ZDIR    = 2;
    localparam int          CFG_INIT    = 3;
    localparam int          CFG_DECEL   = 4;
    localparam int          CFG_NC      = 5;
    localparam int          CFG_SERVO   = 6;
    localparam int          CFG_ABSSET  = 7;
    localparam int          CMD_START   = 0;
    localparam int          CMD_INIT    = 1;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ       = 125;
    localparam int DECEL_TIME_US = 1000;
    localparam int DECEL_CYCLES  = DECEL_TIME_US * CLK_MHZ;
    localparam int SYNC_STAGES   = 3;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_POWER_ON = 2'h0,
        MODE_REVERSE  = 2'h1,
        MODE_ONE_DIR  = 2'h2
    } search_mode_e;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_FAST   = 7'h02,
        ST_SLOW   = 7'h04,
        ST_ZWAIT  = 7'h08,
        ST_HALT   = 7'h10,
        ST_RETURN = 7'h20,
        ST_ERR    = 7'h40
    } search_state_e;

    typedef struct packed {
        logic cw_limit;
        logic ccw_limit;
        logic proximity;
        logic phase_z;
    } axis_pins_s;

endpackage

/* test/servo_drive_model.sv */
// Behavioural servo drive and encoder facing the origin search sequencer.
// Assumes run and data request outputs come on the same clock.
`timescale 1ns/1ps
module servo_drive_model
    import origin_search_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_cw_run,
    input  wire logic        i_ccw_run,
    input  wire logic        i_data_request,
    input  wire logic        i_z_en,
    input  wire logic        i_load,
    input  wire logic [31:0] i_load_pos,
    input  wire logic [3:0]  i_step_div,
    output axis_pins_s       o_pins,
    output logic             o_step = 1'b0,
    output logic             o_step_up = 1'b0,
    output logic             o_abs_valid = 1'b0,
    output logic      [31:0] o_abs_pos,
    output int               o_pos = 0
);
    int   cnt   = 0;
    int   dly   = 0;
    logic req_q = 1'b0;

    // ----------------------------------------------------------------
    // Motion and encoder
    // ----------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        o_step      <= 1'b0;
        o_abs_valid <= 1'b0;
        req_q       <= i_data_request;
        if (i_load) begin
            o_pos <= $signed(i_load_pos);
            cnt   <= 0;
        end else if (i_cw_run ^ i_ccw_run) begin
            if (cnt >= int'(i_step_div)) begin
                cnt       <= 0;
                o_pos     <= o_pos + (i_cw_run ? 1 : -1);
                o_step    <= 1'b1;
                o_step_up <= i_cw_run;
            end else begin
                cnt <= cnt + 1;
            end
        end
        if (i_data_request && !req_q) begin
            dly <= 20;
        end else if (dly > 1) begin
            dly <= dly - 1;
        end else if (dly == 1) begin
            dly         <= 0;
            o_abs_valid <= 1'b1;
        end
    end

    // Data lines carry garbage outside the valid pulse.
    assign o_abs_pos = o_abs_valid ? 32'(o_pos) : ~32'(o_pos);
    assign o_pins    = {o_pos >= 100, o_pos <= -100,
                        o_pos >= -30 && o_pos <= -10,
                        i_z_en && (((o_pos % 16) + 16) % 16 == 5)};
endmodule

/* test/origin_search_sequencer_test.sv */
// Self-checking bench for the origin search sequencer.
// Assumes the servo drive model stands on the axis side.
`timescale 1ns/1ps
module origin_search_sequencer_test
    import origin_search_pkg::*;
;
    logic        i_ref_clk = 1'b0;
    logic        i_nrst    = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [4:0]  paddr     = 5'h00;
    logic [31:0] pwdata    = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, step, step_up, abs_valid;
    logic [31:0] abs_pos;
    axis_pins_s  pins;
    logic        cw_run, ccw_run, high_speed, cpulse, servo, request;
    logic        z_en      = 1'b1;
    logic        load      = 1'b0;
    logic [31:0] load_pos  = 32'h0;
    logic [3:0]  step_div  = 4'h8;
    logic [31:0] lfsr      = 32'h0001219d;
    logic [31:0] rd, st, home;
    logic        err, prev, seen_ccw, seen_cp;
    int          mpos;
    int          n_mismatch = 0;
    int          n_checks   = 0;

    origin_search_sequencer #(.HALT_CYCLES(8)) dut_u (
        .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_pins(pins), .i_step(step),
        .i_step_up(step_up), .i_abs_valid(abs_valid), .i_abs_pos(abs_pos),
        .o_cw_run(cw_run), .o_ccw_run(ccw_run), .o_high_speed(high_speed),
        .o_counter_pulse(cpulse), .o_servo_run(servo),
        .o_encoder_data_request(request));

    servo_drive_model mdl_u (
        .i_ref_clk(i_ref_clk), .i_cw_run(cw_run), .i_ccw_run(ccw_run),
        .i_data_request(request), .i_z_en(z_en), .i_load(load),
        .i_load_pos(load_pos), .i_step_div(step_div), .o_pins(pins),
        .o_step(step), .o_step_up(step_up), .o_abs_valid(abs_valid),
        .o_abs_pos(abs_pos), .o_pos(mpos));

    initial forever #4 i_ref_clk = ~i_ref_clk;

    always @(negedge i_ref_clk) begin
        if (ccw_run === 1'b1) seen_ccw = 1'b1;
        if (cpulse === 1'b1) seen_cp = 1'b1;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge i_ref_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge i_ref_clk);
        penable <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge i_ref_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_end;
        for (int i = 0; i < 6000; i++) begin
            apb(1'b0, STATUS_ADDR, 32'h0);
            if (rd[1:0] !== 2'b00) break;
        end
        st = rd;
    endtask

    task automatic search(input logic [7:0] cfg, input int p);
        lfsr = lfsr_next(lfsr);
        @(posedge i_ref_clk);
        step_div <= 4'h8 | {1'b0, lfsr[2:0]};
        load     <= 1'b1;
        load_pos <= 32'(p);
        @(posedge i_ref_clk);
        load <= 1'b0;
        repeat (10) @(posedge i_ref_clk);
        apb(1'b1, CFG_ADDR, {24'h0, cfg});
        seen_ccw = 1'b0;
        seen_cp = 1'b0;
        apb(1'b1, CMD_ADDR, 32'h1);
        repeat (3) @(negedge i_ref_clk);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge i_ref_clk);
        n_mismatch++;
        complete_run;
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        apb(1'b0, CFG_ADDR, 32'h0);
        chk("cfg reset", {24'h0, CFG_RESET}, rd);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk("idle state", 32'h1, {25'h0, rd[9:3]});
        apb(1'b1, 5'h14, 32'hffffffff);
        chk("unmapped err", 32'h1, 32'(err));
        apb(1'b0, 5'h14, 32'h0);
        chk("unmapped data", 32'h0, rd);
        lfsr = lfsr_next(lfsr);
        home = 32'h1e + {27'h0, lfsr[4:0]};
        @(posedge i_ref_clk);
        load     <= 1'b1;
        load_pos <= home;
        @(posedge i_ref_clk);
        load     <= 1'b0;
        repeat (10) @(posedge i_ref_clk);
        prev = request;
        apb(1'b1, CFG_ADDR, 32'hc5);
        for (int i = 0; i < 8; i++) begin
            @(negedge i_ref_clk);
            if (servo === 1'b1) break;
            prev = request;
        end
        chk("request before run", 32'h0, 32'(prev));
        chk("request with run", 32'h1, 32'(request));
        repeat (30) @(posedge i_ref_clk);
        apb(1'b0, POS_ADDR, 32'h0);
        chk("absolute pos", home, rd);
        apb(1'b0, HOME_ADDR, 32'h0);
        chk("home pos", home, rd);
        for (int d = 0; d < 2; d++) begin
            search(d ? 8'hd5 : 8'hc5, 50);
            chk("start cw", 32'h1, 32'(cw_run));
            chk("fast start", 32'h1, 32'(high_speed));
            wait_end;
            chk("done", 32'h1, {30'h0, st[1:0]});
            apb(1'b0, POS_ADDR, 32'h0);
            chk("origin pos", 32'h0, rd);
            chk("model at z", 32'h5, 32'(mpos));
            chk("reversed", 32'h1, 32'(seen_ccw));
            chk("counter pulse", d ? 32'h0 : 32'h1, 32'(seen_cp));
        end
        search(8'hc4, 5);
        wait_end;
        chk("return done", 32'h1, {30'h0, st[1:0]});
        apb(1'b0, POS_ADDR, 32'h0);
        chk("return pos", home, rd);
        chk("model back", home + 32'h5, 32'(mpos));
        apb(1'b1, CMD_ADDR, 32'h2);
        apb(1'b0, POS_ADDR, 32'h0);
        chk("init pos", 32'h0, rd);
        search(8'hc5, -20);
        chk("start ccw", 32'h1, 32'(ccw_run));
        repeat (12) @(negedge i_ref_clk);
        chk("slow in prox", 32'h0, 32'(high_speed));
        wait_end;
        chk("done prox", 32'h1, {30'h0, st[1:0]});
        z_en <= 1'b0;
        search(8'hc5, 50);
        wait_end;
        chk("no z error", 32'h2, {30'h0, st[1:0]});
        repeat (40) @(negedge i_ref_clk);
        chk("held stop", 32'h0, {30'h0, cw_run, ccw_run});
        z_en <= 1'b1;
        search(8'hc6, 50);
        wait_end;
        chk("one dir error", 32'h2, {30'h0, st[1:0]});
        complete_run;
    end
endmodule
